// ===== bridge_cfg_defs.svh
// offsets, field positions, reset values of the bridge config group
`ifndef BRIDGE_CFG_DEFS_SVH
`define BRIDGE_CFG_DEFS_SVH

// dword offsets (byte addresses)
`define OFF_GPIO_DATA_CONTROL 8'h78
`define OFF_SEC_IRQ_WORD 8'h7C
`define OFF_EXT_BUS_CAP 8'h80

// gpio word field positions
`define GPIO_OUT_CLR_LSB 12
`define GPIO_OUT_SET_LSB 16
`define GPIO_OE_CLR_LSB 20
`define GPIO_OE_SET_LSB 24
`define GPIO_IN_LSB 28
`define GPIO_RST 4'h0

// secondary interrupt word field positions
`define IRQ_ROUTING_LSB 0
`define IRQ_PIN_LSB 8
`define BURST_NEED_LSB 16
`define ACCESS_INTERVAL_LSB 24
`define IRQ_ROUTING_RST 8'h00
`define IRQ_PIN_FORWARD 8'h01
`define IRQ_PIN_REVERSE 8'h00
`define BURST_NEED_RST 8'h00
`define ACCESS_INTERVAL_RST 8'h00

// capability header and secondary status word
`define CAP_ID_LSB 0
`define CAP_NEXT_LSB 8
`define CAP_ID_VALUE 8'h07
`define CAP_NEXT_VALUE 8'h90
`define ST_WIDE_BUS_BIT 16
`define ST_FAST_CLK_BIT 17
`define ST_FLAG_LSB 18
`define ST_FLAG_COUNT 4
`define FLAG_SPLIT_DISCARD 0
`define FLAG_UNEXP_SPLIT 1
`define FLAG_SPLIT_OVERRUN 2
`define FLAG_SPLIT_DELAYED 3
`define ST_FLAG_RST 4'h0
`define ST_CLK_LSB 22
`define ST_CLK_RST 3'h0
`define ST_RESERVED_LSB 25

`endif

// ===== bridge_cfg_pkg.sv
// types shared by the bridge config group
`default_nettype none
package bridge_cfg_pkg;
   typedef logic [31:0] cfg_word_t;
   typedef logic [3:0] cfg_be_t;
   typedef logic [7:0] cfg_addr_t;
   typedef logic [7:0] cfg_byte_t;
   typedef logic [2:0] clk_code_t;
endpackage : bridge_cfg_pkg
`default_nettype wire

// ===== cfg_wr_if.sv
// decoded configuration write carried to the register sub-blocks
`default_nettype none
interface cfg_wr_if;
   import bridge_cfg_pkg::*;
   logic wr_gpio;
   logic wr_status;
   cfg_word_t wdata;
   cfg_be_t be;
   modport ctrl (output wr_gpio, output wr_status, output wdata, output be);
   modport regs (input wr_gpio, input wr_status, input wdata, input be);
endinterface : cfg_wr_if
`default_nettype wire

// ===== gpio_bank.sv
// general-purpose pins with set/clear control of levels and enables
`include "bridge_cfg_defs.svh"
`default_nettype none
module gpio_bank
   import bridge_cfg_pkg::*;
#(
   parameter int W = 4
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // decoded writes
   cfg_wr_if.regs wr,
   // pins
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] out_q,
   output logic [W-1:0] oe_q,
   output logic [W-1:0] in_q
);
   logic [W-1:0] out_clr;
   logic [W-1:0] out_set;
   logic [W-1:0] oe_clr;
   logic [W-1:0] oe_set;

   // strobes per field, gated by their byte lane
   assign out_clr = wr.wdata[`GPIO_OUT_CLR_LSB +: W]
      & {W{wr.wr_gpio & wr.be[1]}};
   assign out_set = wr.wdata[`GPIO_OUT_SET_LSB +: W]
      & {W{wr.wr_gpio & wr.be[2]}};
   assign oe_clr = wr.wdata[`GPIO_OE_CLR_LSB +: W]
      & {W{wr.wr_gpio & wr.be[2]}};
   assign oe_set = wr.wdata[`GPIO_OE_SET_LSB +: W]
      & {W{wr.wr_gpio & wr.be[3]}};

   // output levels; set beats clear when both are written at once
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         out_q <= `GPIO_RST;
      else
         out_q <= (out_q & ~out_clr) | out_set;
   end

   // output enables, same set/clear policy
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         oe_q <= `GPIO_RST;
      else
         oe_q <= (oe_q & ~oe_clr) | oe_set;
   end

   // input levels registered for read-back
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         in_q <= `GPIO_RST;
      else
         in_q <= pin_in;
   end
endmodule : gpio_bank
`default_nettype wire

// ===== status_flags.sv
// sticky split-transaction flags, write one to clear
`include "bridge_cfg_defs.svh"
`default_nettype none
module status_flags
   import bridge_cfg_pkg::*;
#(
   parameter int N = 4
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // decoded writes
   cfg_wr_if.regs wr,
   // events and flags
   input wire logic [N-1:0] set_evt,
   output logic [N-1:0] flag_q
);
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_flag
         logic clr;
         // clear only from the status byte lane
         assign clr = wr.wr_status & wr.be[2] & wr.wdata[`ST_FLAG_LSB + i];
         // an event in the clearing cycle is kept: set wins
         always_ff @(posedge sys_clk)
         begin
            if (!reset_n)
               flag_q[i] <= 1'b0;
            else if (set_evt[i])
               flag_q[i] <= 1'b1;
            else if (clr)
               flag_q[i] <= 1'b0;
         end
      end
   endgenerate
endmodule : status_flags
`default_nettype wire

// ===== bridge_cfg_regs.sv
// gpio, secondary interrupt, capability header and secondary status regs
// Contract
// - four gpio pins: w1c/w1s levels and enables, inputs at 31:28, reset zero
// - 8-bit read-write secondary irq routing byte, forward only, resets zero; the code stores and reads it back in both modes
// - interrupt pin byte reads 01h in forward mode, 00h in reverse
// - burst need byte at 23:16, forward only, resets zero
// - access interval byte at 31:24, forward only, resets zero
// - capability identifier byte always reads 07h
// - next capability pointer byte always reads 90h
// - bit 16 is one in forward mode with wide strap high, else zero
// - bit 17 reads one in forward mode, zero in reverse
// - bit 18 sets on discarded split completion, forward only, clearable
// - bit 19 sets on unexpected split completion, reverse only
// - bit 20 sets when split completion is retried for buffer full
// - bit 21 sets when split request exceeds downstream commitment room
// - bits 24:22 give secondary clock code forward, zero in reverse
`include "bridge_cfg_defs.svh"
`default_nettype none
module bridge_cfg_regs
   import bridge_cfg_pkg::*;
#(
   parameter int GPIO_W = 4,
   parameter cfg_byte_t BURST_NEED = `BURST_NEED_RST,
   parameter cfg_byte_t ACCESS_INTERVAL = `ACCESS_INTERVAL_RST
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // configuration access
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire cfg_addr_t cfg_addr,
   input wire cfg_be_t cfg_be,
   input wire cfg_word_t cfg_wdata,
   output cfg_word_t cfg_rdata_q,
   output logic cfg_rd_ack_q,
   // straps, sampled while reset is held
   input wire logic forward_mode,
   input wire logic wide_bus_strap,
   // secondary bus clock code from the clock detector
   input wire clk_code_t sec_clk_code,
   // split transaction events, one-cycle pulses
   input wire logic split_cpl_discard,
   input wire logic unexp_split_cpl,
   input wire logic split_cpl_overrun,
   input wire logic split_req_delayed,
   // general-purpose pins
   input wire logic [GPIO_W-1:0] gpio_in,
   output logic [GPIO_W-1:0] gpio_out_q,
   output logic [GPIO_W-1:0] gpio_oe_q,
   // interrupt routing for the interrupt controller side
   output cfg_byte_t sec_irq_routing_q
);
   cfg_wr_if wr_bus ();

   logic forward_q;
   logic wide_q;
   clk_code_t clk_code_q;
   cfg_byte_t irq_routing_q;
   logic [GPIO_W-1:0] gpio_in_q;
   logic [`ST_FLAG_COUNT-1:0] flag_set;
   logic [`ST_FLAG_COUNT-1:0] flag_q;
   logic [`ST_FLAG_COUNT-1:0] flag_vis;
   cfg_word_t rd_word;

   // dword match on the byte address; low two bits are ignored
   function automatic logic hit(input cfg_addr_t a, input cfg_addr_t off);
      hit = (a[7:2] == off[7:2]);
   endfunction : hit

   // place one byte into a lane of a word
   function automatic cfg_word_t lane(input cfg_byte_t b, input int lsb);
      lane = cfg_word_t'(b) << lsb;
   endfunction : lane

   // mode straps latched during reset so mode cannot shift mid-run
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         forward_q <= forward_mode;
         wide_q <= wide_bus_strap;
      end
   end

   // clock code registered so read data has a clean source
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         clk_code_q <= `ST_CLK_RST;
      else
         clk_code_q <= sec_clk_code;
   end

   // write decode handed to the sub-blocks
   assign wr_bus.wr_gpio = cfg_wr & hit(cfg_addr, `OFF_GPIO_DATA_CONTROL);
   assign wr_bus.wr_status = cfg_wr & hit(cfg_addr, `OFF_EXT_BUS_CAP);
   assign wr_bus.wdata = cfg_wdata;
   assign wr_bus.be = cfg_be;

   // general-purpose pins
   gpio_bank #(
      .W(GPIO_W)
   ) u_gpio (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr(wr_bus),
      .pin_in(gpio_in),
      .out_q(gpio_out_q),
      .oe_q(gpio_oe_q),
      .in_q(gpio_in_q)
   );

   // routing byte; stored, read back and driven on sec_irq_routing_q in both modes
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         irq_routing_q <= `IRQ_ROUTING_RST;
      else if (cfg_wr & cfg_be[0] & hit(cfg_addr, `OFF_SEC_IRQ_WORD))
         irq_routing_q <= cfg_wdata[`IRQ_ROUTING_LSB +: 8];
   end
   assign sec_irq_routing_q = irq_routing_q;

   // events qualified by mode; flags that a mode forbids never set
   always_comb
   begin
      flag_set = '0;
      flag_set[`FLAG_SPLIT_DISCARD] = split_cpl_discard & forward_q;
      flag_set[`FLAG_UNEXP_SPLIT] = unexp_split_cpl & ~forward_q;
      flag_set[`FLAG_SPLIT_OVERRUN] = split_cpl_overrun;
      flag_set[`FLAG_SPLIT_DELAYED] = split_req_delayed;
   end

   // sticky flags, write one to clear
   status_flags #(
      .N(`ST_FLAG_COUNT)
   ) u_flags (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .wr(wr_bus),
      .set_evt(flag_set),
      .flag_q(flag_q)
   );

   // mode-dependent visibility of the two one-sided flags
   always_comb
   begin
      flag_vis = flag_q;
      flag_vis[`FLAG_SPLIT_DISCARD] =
         flag_q[`FLAG_SPLIT_DISCARD] & forward_q;
      flag_vis[`FLAG_UNEXP_SPLIT] =
         flag_q[`FLAG_UNEXP_SPLIT] & ~forward_q;
   end

   // read data mux; unmapped offsets read as zero
   always_comb
   begin
      rd_word = '0;
      if (hit(cfg_addr, `OFF_GPIO_DATA_CONTROL))
      begin
         // set and clear fields read back the current state
         rd_word[`GPIO_OUT_CLR_LSB +: GPIO_W] = gpio_out_q;
         rd_word[`GPIO_OUT_SET_LSB +: GPIO_W] = gpio_out_q;
         rd_word[`GPIO_OE_CLR_LSB +: GPIO_W] = gpio_oe_q;
         rd_word[`GPIO_OE_SET_LSB +: GPIO_W] = gpio_oe_q;
         rd_word[`GPIO_IN_LSB +: GPIO_W] = gpio_in_q;
      end
      else if (hit(cfg_addr, `OFF_SEC_IRQ_WORD))
      begin
         rd_word = lane(irq_routing_q, `IRQ_ROUTING_LSB);
         rd_word = rd_word | lane(forward_q ? `IRQ_PIN_FORWARD
            : `IRQ_PIN_REVERSE, `IRQ_PIN_LSB);
         if (forward_q)
         begin
            rd_word = rd_word | lane(BURST_NEED, `BURST_NEED_LSB);
            rd_word = rd_word
               | lane(ACCESS_INTERVAL, `ACCESS_INTERVAL_LSB);
         end
      end
      else if (hit(cfg_addr, `OFF_EXT_BUS_CAP))
      begin
         rd_word = lane(`CAP_ID_VALUE, `CAP_ID_LSB);
         rd_word = rd_word | lane(`CAP_NEXT_VALUE, `CAP_NEXT_LSB);
         rd_word[`ST_WIDE_BUS_BIT] = forward_q & wide_q;
         rd_word[`ST_FAST_CLK_BIT] = forward_q;
         rd_word[`ST_FLAG_LSB +: `ST_FLAG_COUNT] = flag_vis;
         if (forward_q)
            rd_word[`ST_CLK_LSB +: 3] = clk_code_q;
         rd_word[31:`ST_RESERVED_LSB] = '0;
      end
   end

   // read answer registered, one cycle after the request
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         cfg_rdata_q <= '0;
         cfg_rd_ack_q <= 1'b0;
      end
      else
      begin
         cfg_rd_ack_q <= cfg_rd;
         if (cfg_rd)
            cfg_rdata_q <= rd_word;
      end
   end
endmodule : bridge_cfg_regs
`default_nettype wire

// ===== bridge_cfg_regs_props.sv
// assertions on the ports of the bridge config register group
`default_nettype none
module bridge_cfg_regs_props
   import bridge_cfg_pkg::*;
#(
   parameter int GPIO_W = 4
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // config access
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire cfg_addr_t cfg_addr,
   input wire cfg_be_t cfg_be,
   input wire cfg_word_t cfg_wdata,
   input wire cfg_word_t cfg_rdata_q,
   // straps and events
   input wire logic forward_mode,
   input wire logic wide_bus_strap,
   input wire logic split_cpl_overrun,
   // outputs
   input wire logic [GPIO_W-1:0] gpio_out_q,
   input wire logic [GPIO_W-1:0] gpio_oe_q,
   input wire cfg_byte_t sec_irq_routing_q
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   logic fwd_q;
   logic wide_q;
   logic rd80;
   logic rd7c;
   logic wr78;
   logic wr7c;
   // straps copied the way the block takes them, while reset is low
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         fwd_q <= forward_mode;
         wide_q <= wide_bus_strap;
      end
   end
   // address decode, low two bits ignored
   assign rd80 = cfg_rd && cfg_addr[7:2] == 6'h20;
   assign rd7c = cfg_rd && cfg_addr[7:2] == 6'h1F;
   assign wr78 = cfg_wr && cfg_addr[7:2] == 6'h1E;
   assign wr7c = cfg_wr && cfg_addr[7:2] == 6'h1F;
   // event then a plain read one cycle later
   sequence ovr_seen;
      split_cpl_overrun ##1 (rd80 && !cfg_wr);
   endsequence
   cap_head_a: assert property (
      rd80 |=> cfg_rdata_q[15:0] == 16'h9007)
      else $error("capability header wrong");
   rsvd_zero_a: assert property (rd80 |=> cfg_rdata_q[31:25] == 7'h00)
      else $error("reserved status bits set");
   wide_bit_a: assert property (
      rd80 |=> cfg_rdata_q[16] == (fwd_q && wide_q))
      else $error("wide bus bit wrong");
   fast_bit_a: assert property (rd80 |=> cfg_rdata_q[17] == fwd_q)
      else $error("fast clock bit wrong");
   rev_zero_a: assert property (rd80 && !fwd_q |=>
      cfg_rdata_q[24:22] == 3'h0 && !cfg_rdata_q[18])
      else $error("reverse mode status not zero");
   irq_pin_a: assert property (
      rd7c |=> cfg_rdata_q[15:8] == {7'h00, fwd_q})
      else $error("interrupt pin byte wrong");
   routing_wr_a: assert property (wr7c && cfg_be[0] |=>
      sec_irq_routing_q == $past(cfg_wdata[7:0]))
      else $error("routing byte not written");
   out_set_a: assert property (wr78 && cfg_be[2] |=>
      (gpio_out_q & $past(cfg_wdata[19:16])) == $past(cfg_wdata[19:16]))
      else $error("gpio set missed");
   oe_clr_a: assert property (wr78 && cfg_be[2] && !cfg_be[3] |=>
      (gpio_oe_q & $past(cfg_wdata[23:20])) == 4'h0)
      else $error("gpio enable clear missed");
   overrun_a: assert property (ovr_seen |=> cfg_rdata_q[20])
      else $error("overrun flag not seen");
endmodule : bridge_cfg_regs_props
bind bridge_cfg_regs bridge_cfg_regs_props #(.GPIO_W(GPIO_W)) i_props (
   .sys_clk, .reset_n, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
   .cfg_rdata_q, .forward_mode, .wide_bus_strap, .split_cpl_overrun,
   .gpio_out_q, .gpio_oe_q, .sec_irq_routing_q);
`default_nettype wire

// ===== cfg_host_model.sv
// host model issuing configuration reads and writes
`default_nettype none
module cfg_host_model
   import bridge_cfg_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // requests
   output logic cfg_rd,
   output logic cfg_wr,
   output cfg_addr_t cfg_addr,
   output cfg_be_t cfg_be,
   output cfg_word_t cfg_wdata,
   // answer
   input wire cfg_word_t cfg_rdata_q,
   input wire logic cfg_rd_ack_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle from time zero
   initial
   begin
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end
   // stale lines go inverted so nothing latches them by luck
   task automatic wr(input cfg_addr_t a, input cfg_be_t b, input cfg_word_t w);
      @(negedge sys_clk);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_be = b;
      cfg_wdata = w;
      @(negedge sys_clk);
      cfg_wr = 1'b0;
      cfg_addr = ~a;
      cfg_be = ~b;
      cfg_wdata = ~w;
   endtask : wr
   // answer stands one cycle, taken before the next rising edge
   task automatic rd(input cfg_addr_t a, output cfg_word_t d);
      @(negedge sys_clk);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge sys_clk);
      cfg_rd = 1'b0;
      cfg_addr = ~a;
      d = (cfg_rd_ack_q === 1'b1) ? cfg_rdata_q : 32'hxxxx_xxxx;
   endtask : rd
endmodule : cfg_host_model
`default_nettype wire

// ===== bridge_cfg_regs_tb.sv
// testbench for the bridge config register group
`default_nettype none
module bridge_cfg_regs_tb
   import bridge_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic forward_mode = 1'b1;
   logic wide_bus_strap = 1'b1;
   clk_code_t sec_clk_code = 3'h2;
   logic [3:0] evt = 4'h0;
   logic [3:0] gpio_in = 4'hA;
   logic cfg_rd;
   logic cfg_wr;
   cfg_addr_t cfg_addr;
   cfg_be_t cfg_be;
   cfg_word_t cfg_wdata;
   cfg_word_t cfg_rdata_q;
   logic cfg_rd_ack_q;
   logic [3:0] gpio_out_q;
   logic [3:0] gpio_oe_q;
   cfg_byte_t sec_irq_routing_q;
   int miscompares = 0;
   int tests_run = 0;
   bridge_cfg_regs i_bridge_cfg_regs (.sys_clk, .reset_n, .cfg_rd, .cfg_wr,
      .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_q, .cfg_rd_ack_q,
      .forward_mode, .wide_bus_strap, .sec_clk_code,
      .split_cpl_discard(evt[0]), .unexp_split_cpl(evt[1]),
      .split_cpl_overrun(evt[2]), .split_req_delayed(evt[3]),
      .gpio_in, .gpio_out_q, .gpio_oe_q, .sec_irq_routing_q);
   cfg_host_model i_cfg_host_model (.sys_clk, .cfg_rd, .cfg_wr, .cfg_addr,
      .cfg_be, .cfg_wdata, .cfg_rdata_q, .cfg_rd_ack_q);
   // 250 MHz clock
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic stop_test;
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(input string n, input cfg_word_t s,
      input cfg_word_t e);
      tests_run++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask : check
   task automatic rdchk(input cfg_addr_t a, input cfg_word_t e);
      cfg_word_t d;
      i_cfg_host_model.rd(a, d);
      check("rdata", d, e);
   endtask : rdchk
   // straps held over the last reset edge, reset eight cycles
   task automatic do_reset(input logic f, input logic w);
      @(negedge sys_clk);
      reset_n = 1'b0;
      forward_mode = f;
      wide_bus_strap = w;
      repeat (8) @(negedge sys_clk);
      reset_n = 1'b1;
   endtask : do_reset
   // one-cycle event pulse, cleared at the next falling edge
   task automatic pulse(input logic [3:0] m);
      @(negedge sys_clk);
      evt = m;
      fork
         @(negedge sys_clk) evt = 4'h0;
      join_none
   endtask : pulse
   // hang guard, whole run is under a hundred cycles
   initial
   begin
      #8000;
      miscompares++;
      stop_test;
   end
   initial
   begin
      do_reset(1'b1, 1'b1);
      rdchk(8'h78, 32'hA000_0000);
      rdchk(8'h80, 32'h0083_9007);
      rdchk(8'h7C, 32'h0000_0100);
      i_cfg_host_model.wr(8'h7C, 4'hF, 32'hFFFF_FFA5);
      rdchk(8'h7C, 32'h0000_01A5);
      check("route", {24'h0, sec_irq_routing_q}, 32'h0000_00A5);
      i_cfg_host_model.wr(8'h78, 4'h8, 32'h0F00_0000);
      i_cfg_host_model.wr(8'h78, 4'h4, 32'h00A5_0000);
      i_cfg_host_model.wr(8'h78, 4'h2, 32'h0000_1000);
      rdchk(8'h78, 32'hA554_4000);
      check("pins", {24'h0, gpio_oe_q, gpio_out_q}, 32'h0000_0054);
      pulse(4'hF);
      rdchk(8'h80, 32'h00B7_9007);
      i_cfg_host_model.wr(8'h80, 4'h4, 32'h0010_0000);
      rdchk(8'h80, 32'h00A7_9007);
      i_cfg_host_model.wr(8'h80, 4'hB, 32'hFFFF_FFFF);
      i_cfg_host_model.wr(8'h80, 4'h4, 32'h0000_0000);
      rdchk(8'h80, 32'h00A7_9007);
      i_cfg_host_model.wr(8'h80, 4'h4, 32'h003C_0000);
      rdchk(8'h80, 32'h0083_9007);
      i_cfg_host_model.wr(8'h90, 4'hF, 32'hFFFF_FFFF);
      rdchk(8'h90, 32'h0000_0000);
      do_reset(1'b0, 1'b1);
      rdchk(8'h80, 32'h0000_9007);
      rdchk(8'h7C, 32'h0000_0000);
      rdchk(8'h78, 32'hA000_0000);
      pulse(4'hF);
      rdchk(8'h80, 32'h0038_9007);
      i_cfg_host_model.wr(8'h80, 4'h4, 32'h0008_0000);
      rdchk(8'h80, 32'h0030_9007);
      // forward with a narrow strap; then event and clear in one cycle
      do_reset(1'b1, 1'b0);
      check("pins", {24'h0, gpio_oe_q, gpio_out_q}, 32'h0000_0000);
      rdchk(8'h80, 32'h0082_9007);
      fork
         pulse(4'h1);
         i_cfg_host_model.wr(8'h80, 4'h4, 32'h0004_0000);
      join
      rdchk(8'h80, 32'h0086_9007);
      i_cfg_host_model.wr(8'h80, 4'h4, 32'h0004_0000);
      rdchk(8'h80, 32'h0082_9007);
      stop_test;
   end
endmodule : bridge_cfg_regs_tb
`default_nettype wire
